// ---- rtl/rtp_phase_seq.sv ----
// four-phase sequencer for the extension compensation.
// assumes overflow is a one-cycle pulse and restart marks a timer re-enable.
`timescale 1ns/1ps
module rtp_phase_seq
    import rtp_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic nrst,
    rtp_tick_if.seq   tif
);

    typedef struct packed {
        logic [1:0] phase;
        logic [1:0] ext;
    } rtp_seq_s;

    rtp_seq_s s;
    rtp_seq_s next_s;

    // phase 0 is the first sub-cycle; single pulse mode never compensates
    always_comb begin
        case (s.ext)
            2'h1:    tif.compNow = (s.phase == 2'h0);
            2'h2:    tif.compNow = (s.phase == 2'h0) || (s.phase == 2'h2);
            2'h3:    tif.compNow = (s.phase != 2'h3);
            default: tif.compNow = 1'b0;
        endcase
        if (tif.singlePulse) begin
            tif.compNow = 1'b0;
        end
    end
    assign tif.phase = s.phase;

    // a new setting is taken on restart or when a four-phase period closes
    always_comb begin
        next_s = s;
        if (tif.restart) begin
            next_s.phase = 2'h0;
            next_s.ext = tif.extSel;
        end else if (tif.overflow) begin
            next_s.phase = s.phase + 2'h1;
            if (s.phase == 2'h3) begin
                next_s.ext = tif.extSel;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_restart_phase;
        tif.restart |=> s.phase == 2'h0;
    endproperty
    a_restart_phase: assert property (p_restart_phase) else $error("phase not reset");

    property p_ext_hold;
        tif.overflow && !tif.restart && s.phase != 2'h3 |=> $stable(s.ext);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("extension changed mid period");

endmodule

// ---- rtl/rtp_pkg.sv ----
// package of the reload timer pwm unit: register map, field positions,
// reset values and prescaler sizes.
// assumes an apb slave with 32-bit data; each register sits at four times its index.
package rtp_pkg;

    // register indices, byte address is index times four
    localparam logic [7:0]  IDX_MODE     = 8'hA8;
    localparam logic [7:0]  IDX_COUNT    = 8'hA9;
    localparam logic [7:0]  IDX_RELOAD   = 8'hAA;
    localparam logic [7:0]  IDX_DUTY     = 8'hAB;
    localparam logic [7:0]  IDX_ROUTE    = 8'hAC;
    localparam logic [7:0]  IDX_EXT      = 8'hDE;
    localparam logic [7:0]  IDX_CTRL     = 8'hE0;
    localparam int          ADDR_W       = 10;

    // mode register fields
    localparam int          MODE_PWM_EN  = 0;
    localparam int          MODE_SINGLE  = 1;
    localparam int          MODE_RATE_LO = 4;
    localparam int          MODE_TMR_EN  = 7;

    // route and extension fields
    localparam int          ROUTE_PIN0   = 4;
    localparam int          ROUTE_PIN1   = 5;
    localparam int          EXT_LO       = 4;

    // control and status fields
    localparam int          CTRL_SLOW    = 0;
    localparam int          CTRL_IRQ_EN  = 1;
    localparam int          CTRL_FLAG    = 2;
    localparam int          CTRL_FSTOP   = 3;

    // reset values
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [5:0]  RST_SIX      = 6'h00;
    localparam logic [2:0]  RST_RATE     = 3'h0;

    // counter and prescaler sizes
    localparam logic [7:0]  CNT_TOP      = 8'hFF;
    localparam logic [7:0]  CNT_COMP_AT  = 8'hFE;
    localparam int          PRE_W        = 7;
    localparam logic [6:0]  PRE_MAX      = 7'h7F;

endpackage

// ---- rtl/rtp_prescaler.sv ----
// prescaler: turns the chosen oscillator into a one-cycle count enable.
// assumes slowTick is a one-cycle pulse per slow oscillator period.
`timescale 1ns/1ps
module rtp_prescaler
    import rtp_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic nrst,
    rtp_tick_if.presc tif
);

    typedef struct packed {
        logic [PRE_W-1:0] cnt;
        logic             tick;
    } rtp_pre_s;

    rtp_pre_s s;
    rtp_pre_s next_s;
    logic     srcTick;
    logic [PRE_W-1:0] lastCnt;

    // code 000 divides by 128, each code halves it, 111 passes every edge
    assign lastCnt = PRE_MAX >> tif.rate;
    assign srcTick = tif.slowSel ? tif.slowTick : 1'b1;
    assign tif.tick = s.tick;

    // divider restarts with the timer so the first tick never comes early
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!tif.enable) begin
            next_s.cnt = '0;
        end else if (srcTick) begin
            if (s.cnt >= lastCnt) begin
                next_s.cnt = '0;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_div_bound;
        tif.enable && !tif.slowSel && tif.rate == 3'h7 |=> s.tick;
    endproperty
    a_div_bound: assert property (p_div_bound) else $error("divide by one missed a tick");

    property p_tick_only_enabled;
        !tif.enable |=> !s.tick;
    endproperty
    a_tick_only_enabled: assert property (p_tick_only_enabled)
        else $error("tick while disabled");

endmodule

// ---- rtl/rtp_tick_if.sv ----
// bundle between the timer core, its prescaler and its phase sequencer.
// assumes all three parties run on the one system clock.
`timescale 1ns/1ps
interface rtp_tick_if;
    logic       enable;
    logic [2:0] rate;
    logic       slowSel;
    logic       slowTick;
    logic       tick;
    logic       restart;
    logic       overflow;
    logic       singlePulse;
    logic [1:0] extSel;
    logic       compNow;
    logic [1:0] phase;

    modport presc (input enable, rate, slowSel, slowTick, output tick);
    modport seq   (input restart, overflow, singlePulse, extSel, output compNow, phase);
    modport core  (output enable, rate, slowSel, slowTick, restart, overflow,
                   singlePulse, extSel, input tick, compNow, phase);
endinterface

// ---- rtl/rtp_timer_pwm.sv ----
// top of the reload timer pwm unit: apb registers, 8-bit counter with
// buffered reload, duty compare, pin routing and single-pulse handling.
// assumes apb on sys_clk, gpio levels synchronous, slowOscTick a one-cycle pulse.
`timescale 1ns/1ps
module rtp_timer_pwm
    import rtp_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              slowOscTick,
    input  wire logic              fastOscStop,
    input  wire logic              gpio0Out,
    input  wire logic              gpio0OeN,
    input  wire logic              gpio1Out,
    input  wire logic              gpio1OeN,
    output logic                   pin0Out,
    output logic                   pin0OeN,
    output logic                   pin1Out,
    output logic                   pin1OeN,
    output logic                   timerIrq
);

    typedef struct packed {
        logic        tmrEn;
        logic [2:0]  rate;
        logic        single;
        logic        pwmEn;
        logic        tmrEnD;
        logic [7:0]  count;
        logic [7:0]  reloadBuf;
        logic [7:0]  reloadAct;
        logic [7:0]  duty;
        logic [7:0]  dutyAct;
        logic [5:0]  route;
        logic [5:0]  extReg;
        logic        slowSel;
        logic        irqEn;
        logic        flag;
        logic        pwmLevel;
        logic        pwmLive;
        logic        pin0Out;
        logic        pin0OeN;
        logic        pin1Out;
        logic        pin1OeN;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rtp_state_s;

    rtp_state_s s;
    rtp_state_s next_s;
    rtp_tick_if tif ();

    logic       setup;
    logic       wrDone;
    logic [7:0] idx;
    logic       hit;
    logic       wrMode;
    logic       wrCount;
    logic       wrCtrl;
    logic       step;
    logic       ovf;
    logic [7:0] countInc;
    logic [31:0] readVal;

    // bus decode; a write lands on the access edge where pready is seen
    assign setup = psel && !penable;
    assign wrDone = psel && penable && s.pready && pwrite;
    assign idx = paddr[ADDR_W-1:2];
    assign hit = (paddr[1:0] == 2'b00) && (idx == IDX_MODE || idx == IDX_COUNT ||
                 idx == IDX_RELOAD || idx == IDX_DUTY || idx == IDX_ROUTE ||
                 idx == IDX_EXT || idx == IDX_CTRL);
    assign wrMode = wrDone && idx == IDX_MODE;
    assign wrCount = wrDone && idx == IDX_COUNT;
    assign wrCtrl = wrDone && idx == IDX_CTRL;

    // counting only while enabled, one step per prescaled tick
    assign step = tif.tick && s.tmrEn;
    assign ovf = step && (s.count == CNT_TOP);
    assign countInc = s.count + 8'h01;

    // links to prescaler and phase sequencer
    assign tif.enable = s.tmrEn;
    assign tif.rate = s.rate;
    assign tif.slowSel = s.slowSel;
    assign tif.slowTick = slowOscTick;
    assign tif.restart = s.tmrEn && !s.tmrEnD;
    assign tif.overflow = ovf;
    assign tif.singlePulse = s.single;
    assign tif.extSel = s.extReg[EXT_LO +: 2];

    rtp_prescaler u_presc (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .tif     (tif.presc)
    );

    rtp_phase_seq u_phase (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .tif     (tif.seq)
    );

    // read mux; reload is write-only and reads as zero
    always_comb begin
        readVal = '0;
        case (idx)
            IDX_MODE: begin
                readVal[MODE_TMR_EN] = s.tmrEn;
                readVal[MODE_RATE_LO +: 3] = s.rate;
                readVal[MODE_SINGLE] = s.single;
                readVal[MODE_PWM_EN] = s.pwmEn;
            end
            IDX_COUNT: readVal[7:0] = s.count;
            IDX_DUTY:  readVal[7:0] = s.duty;
            IDX_ROUTE: readVal[5:0] = s.route;
            IDX_EXT:   readVal[5:0] = s.extReg;
            IDX_CTRL: begin
                readVal[CTRL_SLOW] = s.slowSel;
                readVal[CTRL_IRQ_EN] = s.irqEn;
                readVal[CTRL_FLAG] = s.flag;
                readVal[CTRL_FSTOP] = fastOscStop;
            end
            default:   readVal = '0;
        endcase
    end

    // whole next state; hardware events first, software writes after, except the flag clear which comes before the overflow set
    always_comb begin
        next_s = s;
        next_s.tmrEnD = s.tmrEn;

        // apb: answer prepared in setup, pready high for the one access cycle
        next_s.pready = setup;
        next_s.pslverr = setup && !hit;
        if (setup) begin
            next_s.prdata = readVal;
        end

        // enabling re-arms the cycle from the loaded values
        if (tif.restart) begin
            next_s.reloadAct = s.reloadBuf;
            next_s.dutyAct = s.duty;
            next_s.pwmLevel = s.duty > s.reloadBuf;
        end

        // counter, buffered reload and duty compare
        if (ovf) begin
            next_s.reloadAct = s.reloadBuf;
            next_s.dutyAct = s.duty;
            next_s.count = s.reloadBuf;
            next_s.pwmLevel = s.duty > s.reloadBuf;
        end else if (step) begin
            next_s.count = countInc;
            if (countInc == s.dutyAct) begin
                next_s.pwmLevel = 1'b0;
            end
            if (tif.compNow && s.count == CNT_COMP_AT) begin
                next_s.pwmLevel = 1'b1;
            end
        end

        // single pulse ends at its overflow; a software set in that cycle wins
        if (ovf && s.single && s.pwmLive) begin
            next_s.pwmEn = 1'b0;
        end

        // hand-over waits for the first tick; a finished pulse drops it at once, no glitch
        if (!(s.tmrEn && s.pwmEn) || (ovf && s.single)) begin
            next_s.pwmLive = 1'b0;
        end else if (tif.tick) begin
            next_s.pwmLive = 1'b1;
        end

        // sticky flag: a clear write of zero loses against a same-cycle overflow
        if (wrCtrl && !pwdata[CTRL_FLAG]) begin
            next_s.flag = 1'b0;
        end
        if (ovf) begin
            next_s.flag = 1'b1;
        end

        // register writes
        if (wrMode) begin
            next_s.tmrEn = pwdata[MODE_TMR_EN];
            next_s.rate = pwdata[MODE_RATE_LO +: 3];
            next_s.single = pwdata[MODE_SINGLE];
            next_s.pwmEn = pwdata[MODE_PWM_EN];
        end
        if (wrCount) begin
            next_s.count = pwdata[7:0];
        end
        if (wrDone && idx == IDX_RELOAD) begin
            next_s.reloadBuf = pwdata[7:0];
        end
        if (wrDone && idx == IDX_DUTY) begin
            next_s.duty = pwdata[7:0];
        end
        if (wrDone && idx == IDX_ROUTE) begin
            next_s.route = pwdata[5:0];
        end
        if (wrDone && idx == IDX_EXT) begin
            next_s.extReg = pwdata[5:0];
        end
        if (wrCtrl) begin
            next_s.slowSel = pwdata[CTRL_SLOW];
            next_s.irqEn = pwdata[CTRL_IRQ_EN];
        end

        // interrupt output follows the flag gated by its enable
        next_s.irq = next_s.flag && next_s.irqEn;

        // each pin carries pwm only when routed and live, else its gpio levels
        if (s.pwmLive && s.route[ROUTE_PIN0]) begin
            next_s.pin0Out = s.pwmLevel;
            next_s.pin0OeN = 1'b0;
        end else begin
            next_s.pin0Out = gpio0Out;
            next_s.pin0OeN = gpio0OeN;
        end
        if (s.pwmLive && s.route[ROUTE_PIN1]) begin
            next_s.pin1Out = s.pwmLevel;
            next_s.pin1OeN = 1'b0;
        end else begin
            next_s.pin1Out = gpio1Out;
            next_s.pin1OeN = gpio1OeN;
        end
    end

    // single state register; pins idle as released inputs under reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.pin0OeN <= 1'b1;
            s.pin1OeN <= 1'b1;
            s.rate <= RST_RATE;
            s.count <= RST_BYTE;
            s.route <= RST_SIX;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign pin0Out = s.pin0Out;
    assign pin0OeN = s.pin0OeN;
    assign pin1Out = s.pin1Out;
    assign pin1OeN = s.pin1OeN;
    assign timerIrq = s.irq;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_wrap;
        ovf && !wrCtrl;
    endsequence

    property p_flag_set;
        s_wrap |=> s.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");

    property p_reload;
        ovf && !wrCount |=> s.count == $past(s.reloadBuf);
    endproperty
    a_reload: assert property (p_reload) else $error("counter not reloaded");

    property p_buffer_hold;
        !ovf && !tif.restart |=> $stable(s.reloadAct) && $stable(s.dutyAct);
    endproperty
    a_buffer_hold: assert property (p_buffer_hold) else $error("active value moved early");

    property p_high_start;
        ovf && s.duty > s.reloadBuf |=> s.pwmLevel;
    endproperty
    a_high_start: assert property (p_high_start) else $error("cycle did not start high");

    property p_low_match;
        step && !ovf && countInc == s.dutyAct && !(tif.compNow && s.count == CNT_COMP_AT)
            |=> !s.pwmLevel;
    endproperty
    a_low_match: assert property (p_low_match) else $error("no fall at duty match");

    property p_gpio_return;
        !(s.tmrEn && s.pwmEn) |=> !s.pwmLive ##1 (pin0OeN == $past(gpio0OeN, 1));
    endproperty
    a_gpio_return: assert property (p_gpio_return) else $error("pin not back to gpio");

    property p_hold;
        !s.tmrEn && !wrCount |=> $stable(s.count) && (!s.flag || $past(s.flag));
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved while disabled");

    property p_single_clear;
        ovf && s.single && s.pwmLive && !wrMode |=> !s.pwmEn ##1 !s.pwmLive;
    endproperty
    a_single_clear: assert property (p_single_clear) else $error("pulse enable not cleared");

    property p_no_route;
        s.route[ROUTE_PIN1:ROUTE_PIN0] == 2'b00 |=> pin0OeN == $past(gpio0OeN)
            && pin1OeN == $past(gpio1OeN);
    endproperty
    a_no_route: assert property (p_no_route) else $error("pwm on unrouted pin");

    property p_irq;
        s_wrap ##0 s.irqEn |=> timerIrq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

// ---- tb/tb_rtp_timer_pwm.sv ----
// testbench of the reload timer pwm unit: apb register tasks, pwm high-time
// counts on both pins, flag, routing, extension and single pulse.
// assumes every apb access is answered within a few cycles of its setup.
`timescale 1ns/1ps
module tb_rtp_timer_pwm
    import rtp_pkg::*;
;
    logic              sys_clk;
    logic              nrst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              gpio0Out;
    logic              pin0Out;
    logic              pin0OeN;
    logic              pin1Out;
    logic              pin1OeN;
    logic              timerIrq;
    logic              slowOscTick;
    logic [1:0]        slowCnt = 2'h0;
    logic              fastStop;
    logic [31:0]       held;
    int                pulseHi;
    logic [31:0]       rd;
    logic              err;
    int                errors;
    int                checks;

    // gpio of the first pin is an input with high level, second pin low input
    rtp_timer_pwm i_dut (
        .sys_clk     (sys_clk),
        .nrst        (nrst),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .slowOscTick (slowOscTick),
        .fastOscStop (fastStop),
        .gpio0Out    (gpio0Out),
        .gpio0OeN    (1'b1),
        .gpio1Out    (1'b0),
        .gpio1OeN    (1'b1),
        .pin0Out     (pin0Out),
        .pin0OeN     (pin0OeN),
        .pin1Out     (pin1Out),
        .pin1OeN     (pin1OeN),
        .timerIrq    (timerIrq)
    );

    // 125 MHz system clock
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    // slow oscillator stand-in: one pulse every fourth system clock
    always @(posedge sys_clk) slowCnt <= slowCnt + 2'h1;
    assign slowOscTick = (slowCnt == 2'h3);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one apb transfer; the wait for pready is bounded, never assumed
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            print_verdict();
        end else begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // counts high cycles on a pin that must stay driven throughout
    task automatic measure(input logic sel, input int n, input int exp);
        int hi;
        int off;
        hi = 0;
        off = 0;
        repeat (n) begin
            @(posedge sys_clk);
            if ((sel ? pin1OeN : pin0OeN) !== 1'b0) off++;
            if ((sel ? pin1Out : pin0Out) === 1'b1) hi++;
        end
        chk(32'(off), 32'h0);
        chk(32'(hi), 32'(exp));
    endtask

    // stop, load count and reload alike, pwm enable before timer enable
    task automatic start(input logic [2:0] rate, input logic [7:0] rl,
                         input logic [7:0] dt, input logic pulse);
        apb(1'b1, IDX_MODE, 32'h0);
        apb(1'b1, IDX_COUNT, {24'h0, rl});
        apb(1'b1, IDX_RELOAD, {24'h0, rl});
        apb(1'b1, IDX_DUTY, {24'h0, dt});
        apb(1'b1, IDX_MODE, {24'h0, 1'b0, rate, 2'b00, pulse, 1'b1});
        apb(1'b1, IDX_MODE, {24'h0, 1'b1, rate, 2'b00, pulse, 1'b1});
    endtask

    initial begin
        errors = 0;
        checks = 0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        gpio0Out = 1'b1;
        fastStop = 1'b0;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        // reset values, write-only reload and an unmapped word
        apb(1'b0, IDX_COUNT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, IDX_DUTY, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, IDX_RELOAD, 32'h5A);
        apb(1'b0, IDX_RELOAD, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        // period of 16 counts, high while counting F0..F7
        apb(1'b1, IDX_ROUTE, 32'h10);
        start(3'h7, 8'hF0, 8'hF8, 1'b0);
        repeat (20) @(posedge sys_clk);
        measure(1'b0, 160, 80);
        chk({31'h0, pin1OeN}, 32'h1);
        apb(1'b0, IDX_CTRL, 32'h0);
        chk({31'h0, rd[CTRL_FLAG]}, 32'h1);
        // new period and duty wait for the next reload
        apb(1'b1, IDX_RELOAD, 32'hE0);
        repeat (80) @(posedge sys_clk);
        measure(1'b0, 320, 240);
        apb(1'b1, IDX_DUTY, 32'hE0);
        repeat (80) @(posedge sys_clk);
        measure(1'b0, 320, 0);
        // disabling the timer hands the pin back to gpio and freezes counting
        apb(1'b1, IDX_MODE, 32'h71);
        repeat (3) @(posedge sys_clk);
        chk({30'h0, pin0OeN, pin0Out}, 32'h3);
        apb(1'b1, IDX_CTRL, 32'h0);
        apb(1'b0, IDX_COUNT, 32'h0);
        held = rd;
        repeat (100) @(posedge sys_clk);
        apb(1'b0, IDX_CTRL, 32'h0);
        chk({31'h0, rd[CTRL_FLAG]}, 32'h0);
        apb(1'b0, IDX_COUNT, 32'h0);
        chk(rd, held);
        // prescale codes: divisor 128 >> code
        for (int r = 6; r >= 4; r--) begin
            start(r[2:0], 8'hF0, 8'hF8, 1'b0);
            repeat (40 * (128 >> r)) @(posedge sys_clk);
            measure(1'b0, 160 * (128 >> r), 80 * (128 >> r));
        end
        // interrupt follows flag when enabled, pwm still running
        apb(1'b1, IDX_CTRL, 32'h2);
        start(3'h7, 8'hF0, 8'hF8, 1'b0);
        repeat (40) @(posedge sys_clk);
        chk({31'h0, timerIrq}, 32'h1);
        // pwm enable cleared keeps counting but releases the pin
        gpio0Out <= 1'b0;
        apb(1'b1, IDX_MODE, 32'hF0);
        repeat (3) @(posedge sys_clk);
        chk({30'h0, pin0OeN, pin0Out}, 32'h2);
        // second pin only, then no route at all
        apb(1'b1, IDX_ROUTE, 32'h20);
        start(3'h7, 8'hF0, 8'hF8, 1'b0);
        repeat (20) @(posedge sys_clk);
        measure(1'b1, 160, 80);
        chk({31'h0, pin0OeN}, 32'h1);
        apb(1'b1, IDX_ROUTE, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk({30'h0, pin0OeN, pin1OeN}, 32'h3);
        // extension: one extra high count in 0..3 of four sub-cycles
        apb(1'b1, IDX_ROUTE, 32'h10);
        // slow source first: one count per slow pulse, so periods are four times longer
        fastStop <= 1'b1;
        apb(1'b1, IDX_CTRL, 32'h1);
        start(3'h7, 8'hF0, 8'hF8, 1'b0);
        repeat (160) @(posedge sys_clk);
        measure(1'b0, 640, 320);
        apb(1'b0, IDX_CTRL, 32'h0);
        chk({31'h0, rd[CTRL_FSTOP]}, 32'h1);
        apb(1'b1, IDX_CTRL, 32'h0);
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, IDX_EXT, 32'(e << EXT_LO));
            repeat (140) @(posedge sys_clk);
            measure(1'b0, 640, 320 + 10 * e);
        end
        // single pulse: enable bit self-clears and the pin returns to gpio
        // extension is still set: the pulse must not gain the compensation count
        start(3'h7, 8'hF0, 8'hF8, 1'b1);
        pulseHi = 0;
        repeat (60) begin
            @(posedge sys_clk);
            if (pin0Out === 1'b1) pulseHi++;
        end
        chk(32'(pulseHi), 32'h7);
        apb(1'b0, IDX_MODE, 32'h0);
        chk(rd, 32'hF2);
        chk({31'h0, pin0OeN}, 32'h1);
        print_verdict();
    end
endmodule
